// ---- verilog/apr_consts.svh ----
`ifndef APR_CONSTS_SVH
`define APR_CONSTS_SVH

`define APR_BUS_W 16
`define APR_WORD_W 16
`define APR_CHANNELS 6
`define APR_SET_W 96
`define APR_FIFO_DEPTH 8
`define APR_CFG_W 32
`define APR_SER_BITS 96

`define APR_PIN_REF_BUFFER_CTRL_BIT 14
`define APR_PIN_CFG_IN 13
`define APR_PIN_LANE_C 10
`define APR_PIN_LANE_B 9
`define APR_PIN_LANE_A 8
`define APR_PIN_HBF 7
`define APR_PIN_SCLK 6
`define APR_PIN_CHAIN_A 5
`define APR_PIN_CHAIN_B 4
`define APR_PIN_CHAIN_C 3
`define APR_PIN_SEL_C 2
`define APR_PIN_SEL_B 1
`define APR_CTRL_BIT_REF_BUFFER_CTRL_BIT 24

`define APR_SCLK_HALF 8'd8
`define APR_CS_SETUP 8'd8
`define APR_RD_LOW 8'd10
`define APR_RD_HIGH 8'd6

`define APR_REG_CTRL 8'h00
`define APR_REG_CFG 8'h04
`define APR_REG_STATUS 8'h08
`define APR_REG_RES_A 8'h10
`define APR_REG_RES_B 8'h28
`define APR_REG_RES_C 8'h34
`define APR_REG_END 8'h3c

`define APR_CB_START 0
`define APR_CB_IFSEL 1
`define APR_CB_CFGSRC 2
`define APR_CB_BYTE 3
`define APR_CB_HBF 4
`define APR_CB_CHAIN_EN 5
`define APR_CB_SEL_B 6
`define APR_CB_SEL_C 7
`define APR_CB_REFPIN 8
`define APR_CB_CHAIN_LSB 9

`endif

// ---- verilog/apr_pkg.sv ----
package apr_pkg;
  typedef logic [15:0] apr_word_t;
  typedef logic [95:0] apr_set_t;
  typedef logic [31:0] apr_cfg_t;
  typedef enum logic [2:0] {
    APR_IDLE = 3'b000,
    APR_PAR_SETUP = 3'b001,
    APR_PAR_LO = 3'b010,
    APR_PAR_HI = 3'b011,
    APR_SER_SETUP = 3'b100,
    APR_SER_HI = 3'b101,
    APR_SER_LO = 3'b110,
    APR_END = 3'b111
  } apr_hstate_t;
endpackage

// ---- verilog/apr_if.sv ----
`timescale 1ns/1ps
interface apr_if;
  logic [15:0] devOut;
  logic [15:0] devOe;
  logic [15:0] hostOut;
  logic [15:0] hostOe;
  logic [15:0] busLevel;
  logic interfaceSelect;
  logic configSourceSelect;
  logic byteMode;
  logic csN;
  logic rdN;
  // undriven pins read low, as a board pull-down would
  assign busLevel = (devOe & devOut) | (~devOe & hostOe & hostOut);
  modport dev (input busLevel, input interfaceSelect, input configSourceSelect,
    input byteMode, input csN, input rdN, output devOut, output devOe);
  modport host (input busLevel, output hostOut, output hostOe, output interfaceSelect,
    output configSourceSelect, output byteMode, output csN, output rdN);
endinterface

// ---- verilog/apr_fifo.sv ----
`timescale 1ns/1ps
module apr_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PW:0] count_q, count_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  assign push = inValid && !full_q;
  assign pop = outReady && !empty_q;
  assign inReady = !full_q;
  assign outValid = !empty_q;
  assign outData = mem[rdPtr_q];

  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    full_d = (count_d == DEPTH[PW:0]);
    empty_d = (count_d == '0);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule

// ---- verilog/apr_device.sv ----
// Overview of operation
// - parallel mode: pins form bidirectional 16-bit bus
// - hardware config: low pin enables reference buffers in serial mode
// - software config: control bit 24 governs buffers in serial mode
// - software config: pin 13 is serial config input
// - lane C select high drives channel C
// - lane B select high drives channel B
// - lane C off, lane B on: C1 follows B on lane B
// - lane A carries A, plus C0 if C off
// - both selects low: lane A carries all six
// - byte mode: high-byte-first pin picks first byte
// - chain enable turns pins 5..3 into chain inputs
// - lane select high activates lane, low disables
// - chain input A follows lane A's own words
`timescale 1ns/1ps
`include "apr_consts.svh"
module apr_device (
  input wire logic clk,
  input wire logic rst_n,
  apr_if.dev pins,
  input wire apr_pkg::apr_set_t sampleSet,
  input wire logic sampleValid,
  output logic sampleReady,
  output logic refBufferOn,
  output apr_pkg::apr_cfg_t controlWord
);
  import apr_pkg::*;

  logic [15:0] busS1_q, busS2_q;
  logic [4:0] ctlS1_q, ctlS2_q;
  logic sclkPrev_q, csPrev_q, rdPrev_q;
  logic csN, rdN, serialMode, swConfig, byteMode;
  logic selB, selC, chainEn, hbf, sclk;
  logic csFall, csRise, sclkRise, sclkFall, rdFall, rdRise;

  apr_set_t fifoData, set_q, set_d;
  logic fifoValid, fifoPop;
  apr_set_t laneA_q, laneA_d, laneB_q, laneB_d, laneC_q, laneC_d;
  apr_set_t buildA, buildB, buildC;
  apr_word_t w [6];
  logic [2:0] wordIdx_q, wordIdx_d;
  logic bytePhase_q, bytePhase_d;
  logic reading_q, reading_d;
  apr_cfg_t cfgShift_q, cfgShift_d, control_q, control_d;
  logic [5:0] rxCnt_q, rxCnt_d;
  logic refOn_q, refOn_d;
  logic [15:0] devOut_q, devOut_d, devOe_q, devOe_d;
  apr_word_t curWord;
  logic [6:0] posA, posB;

  // every pin is off-domain; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busS1_q <= '0;
      busS2_q <= '0;
      ctlS1_q <= 5'h03;
      ctlS2_q <= 5'h03;
      sclkPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
      rdPrev_q <= 1'b1;
    end else begin
      busS1_q <= pins.busLevel;
      busS2_q <= busS1_q;
      ctlS1_q <= {pins.byteMode, pins.configSourceSelect, pins.interfaceSelect,
                  pins.rdN, pins.csN};
      ctlS2_q <= ctlS1_q;
      sclkPrev_q <= sclk;
      csPrev_q <= csN;
      rdPrev_q <= rdN;
    end
  end

  assign csN = ctlS2_q[0];
  assign rdN = ctlS2_q[1];
  assign serialMode = ctlS2_q[2];
  assign swConfig = ctlS2_q[3];
  assign byteMode = ctlS2_q[4];
  assign selB = busS2_q[`APR_PIN_SEL_B];
  assign selC = busS2_q[`APR_PIN_SEL_C];
  assign chainEn = busS2_q[`APR_PIN_HBF];
  assign hbf = busS2_q[`APR_PIN_HBF];
  assign sclk = busS2_q[`APR_PIN_SCLK];
  assign csFall = csPrev_q && !csN;
  assign csRise = !csPrev_q && csN;
  assign sclkRise = serialMode && !csN && !sclkPrev_q && sclk;
  assign sclkFall = serialMode && !csN && sclkPrev_q && !sclk;
  assign rdFall = !serialMode && !csN && rdPrev_q && !rdN;
  assign rdRise = !rdPrev_q && rdN;

  apr_fifo #(.WIDTH(`APR_SET_W), .DEPTH(`APR_FIFO_DEPTH)) apr_fifo_inst (
    .clk(clk),
    .rst_n(rst_n),
    .inData(sampleSet),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // chain bits enter right behind the lane's own words, not after the padding
  assign posA = selB ? (selC ? 7'd64 : 7'd48) : (selC ? 7'd32 : 7'd0);
  assign posB = selC ? 7'd64 : 7'd48;

  // a frame with nothing queued repeats the previous set
  assign fifoPop = csFall && fifoValid;

  always_comb begin
    set_d = fifoPop ? fifoData : set_q;
    for (int i = 0; i < 6; i++) begin
      w[i] = set_d[95 - 16*i -: 16];
    end
    case ({selB, selC})
      2'b11: begin
        buildA = {w[0], w[1], 64'h0};
        buildB = {w[2], w[3], 64'h0};
        buildC = {w[4], w[5], 64'h0};
      end
      2'b10: begin
        buildA = {w[0], w[1], w[4], 48'h0};
        buildB = {w[2], w[3], w[5], 48'h0};
        buildC = 96'h0;
      end
      2'b01: begin
        buildA = {w[0], w[1], w[2], w[3], 32'h0};
        buildB = 96'h0;
        buildC = {w[4], w[5], 64'h0};
      end
      default: begin
        buildA = {w[0], w[1], w[2], w[3], w[4], w[5]};
        buildB = 96'h0;
        buildC = 96'h0;
      end
    endcase
  end

  always_comb begin
    laneA_d = laneA_q;
    laneB_d = laneB_q;
    laneC_d = laneC_q;
    if (csFall) begin
      laneA_d = buildA;
      laneB_d = buildB;
      laneC_d = buildC;
    end else if (sclkFall) begin
      // upstream bits enter behind our own words
      laneA_d = {laneA_q[94:0], 1'b0};
      laneB_d = {laneB_q[94:0], 1'b0};
      laneC_d = {laneC_q[94:0], 1'b0};
      laneA_d[posA] = chainEn & busS2_q[`APR_PIN_CHAIN_A];
      laneB_d[posB] = chainEn & busS2_q[`APR_PIN_CHAIN_B];
      laneC_d[64] = chainEn & busS2_q[`APR_PIN_CHAIN_C];
    end
  end

  always_comb begin
    wordIdx_d = wordIdx_q;
    bytePhase_d = bytePhase_q;
    reading_d = reading_q;
    if (csFall) begin
      wordIdx_d = 3'h0;
      bytePhase_d = 1'b0;
      reading_d = 1'b0;
    end else if (rdFall) begin
      reading_d = 1'b1;
    end else if (rdRise && reading_q) begin
      reading_d = 1'b0;
      if (byteMode) begin
        bytePhase_d = !bytePhase_q;
      end
      if (!byteMode || bytePhase_q) begin
        wordIdx_d = (wordIdx_q == 3'h5) ? 3'h0 : wordIdx_q + 3'h1;
      end
    end
  end

  always_comb begin
    cfgShift_d = cfgShift_q;
    rxCnt_d = rxCnt_q;
    control_d = control_q;
    if (csFall) begin
      rxCnt_d = 6'h0;
    end else if (sclkRise && swConfig && rxCnt_q != 6'd32) begin
      cfgShift_d = {cfgShift_q[30:0], busS2_q[`APR_PIN_CFG_IN]};
      rxCnt_d = rxCnt_q + 6'h1;
    end
    // a short frame leaves the old control word in force
    if (csRise && swConfig && rxCnt_q == 6'd32) begin
      control_d = cfgShift_q;
    end
  end

  always_comb begin
    refOn_d = refOn_q;
    if (serialMode && swConfig) begin
      refOn_d = !control_q[`APR_CTRL_BIT_REF_BUFFER_CTRL_BIT];
    end else if (serialMode) begin
      refOn_d = !busS2_q[`APR_PIN_REF_BUFFER_CTRL_BIT];
    end
  end

  always_comb begin
    curWord = set_q[95 - 16*wordIdx_q -: 16];
    devOut_d = 16'h0;
    devOe_d = 16'h0;
    if (serialMode) begin
      devOut_d[`APR_PIN_LANE_A] = laneA_q[95];
      devOut_d[`APR_PIN_LANE_B] = laneB_q[95];
      devOut_d[`APR_PIN_LANE_C] = laneC_q[95];
      devOe_d[`APR_PIN_LANE_A] = 1'b1;
      devOe_d[`APR_PIN_LANE_B] = selB;
      devOe_d[`APR_PIN_LANE_C] = selC;
    end else if (reading_q && byteMode) begin
      devOut_d[15:8] = (hbf ^ bytePhase_q) ? curWord[15:8] : curWord[7:0];
      devOe_d[15:8] = 8'hff;
    end else if (reading_q) begin
      devOut_d = curWord;
      devOe_d = 16'hffff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      set_q <= '0;
      laneA_q <= '0;
      laneB_q <= '0;
      laneC_q <= '0;
      wordIdx_q <= 3'h0;
      bytePhase_q <= 1'b0;
      reading_q <= 1'b0;
      cfgShift_q <= '0;
      rxCnt_q <= 6'h0;
      control_q <= '0;
      refOn_q <= 1'b0;
      devOut_q <= 16'h0;
      devOe_q <= 16'h0;
    end else begin
      set_q <= set_d;
      laneA_q <= laneA_d;
      laneB_q <= laneB_d;
      laneC_q <= laneC_d;
      wordIdx_q <= wordIdx_d;
      bytePhase_q <= bytePhase_d;
      reading_q <= reading_d;
      cfgShift_q <= cfgShift_d;
      rxCnt_q <= rxCnt_d;
      control_q <= control_d;
      refOn_q <= refOn_d;
      devOut_q <= devOut_d;
      devOe_q <= devOe_d;
    end
  end

  assign pins.devOut = devOut_q;
  assign pins.devOe = devOe_q;
  assign refBufferOn = refOn_q;
  assign controlWord = control_q;
endmodule

// ---- verilog/apr_host.sv ----
`timescale 1ns/1ps
`include "apr_consts.svh"
module apr_host (
  input wire logic clk,
  input wire logic rst_n,
  apr_if.host pins,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import apr_pkg::*;

  apr_hstate_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [6:0] bitCnt_q, bitCnt_d;
  logic [31:0] ctrl_q, ctrl_d;
  apr_cfg_t cfg_q, cfg_d, cfgShift_q, cfgShift_d;
  logic done_q, done_d;
  apr_set_t capA_q, capA_d, capB_q, capB_d, capC_q, capC_d;
  logic [7:0] byteHold_q, byteHold_d;
  logic sclk_q, sclk_d, csN_q, csN_d, rdN_q, rdN_d;
  logic [15:0] busS1_q, busS2_q, hostOut_q, hostOut_d, hostOe_q, hostOe_d;
  logic wrPend_q, wrPend_d;
  logic [7:0] wrAddr_q, wrAddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic addrPhase;
  logic [7:0] rdAddr;
  logic [3:0] reads;

  assign addrPhase = hsel && htrans[1] && hready;
  assign rdAddr = haddr[7:0];
  assign reads = ctrl_q[`APR_CB_BYTE] ? 4'd12 : 4'd6;

  // zero-wait slave: read data is prepared in the address phase
  always_comb begin
    hrdata_d = hrdata_q;
    wrPend_d = addrPhase && hwrite;
    wrAddr_d = addrPhase ? rdAddr : wrAddr_q;
    if (addrPhase && !hwrite) begin
      hrdata_d = 32'h0;
      if (rdAddr == `APR_REG_CTRL) begin
        hrdata_d = ctrl_q;
      end else if (rdAddr == `APR_REG_CFG) begin
        hrdata_d = cfg_q;
      end else if (rdAddr == `APR_REG_STATUS) begin
        hrdata_d = {30'h0, done_q, state_q != APR_IDLE};
      end else if (rdAddr >= `APR_REG_RES_A && rdAddr < `APR_REG_END) begin
        for (int i = 0; i < 6; i++) begin
          if (rdAddr == `APR_REG_RES_A + 8'(4*i)) hrdata_d = {16'h0, capA_q[95-16*i -: 16]};
        end
        for (int i = 0; i < 3; i++) begin
          if (rdAddr == `APR_REG_RES_B + 8'(4*i)) hrdata_d = {16'h0, capB_q[95-16*i -: 16]};
        end
        for (int i = 0; i < 2; i++) begin
          if (rdAddr == `APR_REG_RES_C + 8'(4*i)) hrdata_d = {16'h0, capC_q[95-16*i -: 16]};
        end
      end
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 8'h1;
    bitCnt_d = bitCnt_q;
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    cfgShift_d = cfgShift_q;
    done_d = done_q;
    capA_d = capA_q;
    capB_d = capB_q;
    capC_d = capC_q;
    byteHold_d = byteHold_q;
    sclk_d = sclk_q;
    csN_d = csN_q;
    rdN_d = rdN_q;
    ctrl_d[`APR_CB_START] = 1'b0;
    if (wrPend_q && wrAddr_q == `APR_REG_CTRL && state_q == APR_IDLE) begin
      ctrl_d = hwdata;
    end
    if (wrPend_q && wrAddr_q == `APR_REG_CFG) begin
      cfg_d = hwdata;
    end
    case (state_q)
      APR_IDLE: begin
        cnt_d = 8'h0;
        bitCnt_d = 7'h0;
        if (ctrl_q[`APR_CB_START]) begin
          done_d = 1'b0;
          csN_d = 1'b0;
          cfgShift_d = cfg_q;
          state_d = ctrl_q[`APR_CB_IFSEL] ? APR_SER_SETUP : APR_PAR_SETUP;
        end
      end
      APR_PAR_SETUP, APR_PAR_HI: begin
        if (cnt_q == (state_q == APR_PAR_SETUP ? `APR_CS_SETUP : `APR_RD_HIGH)) begin
          cnt_d = 8'h0;
          if (bitCnt_q == 7'(reads)) begin
            state_d = APR_END;
          end else begin
            rdN_d = 1'b0;
            state_d = APR_PAR_LO;
          end
        end
      end
      APR_PAR_LO: begin
        if (cnt_q == `APR_RD_LOW) begin
          cnt_d = 8'h0;
          rdN_d = 1'b1;
          bitCnt_d = bitCnt_q + 7'h1;
          state_d = APR_PAR_HI;
          if (!ctrl_q[`APR_CB_BYTE]) begin
            capA_d = {capA_q[79:0], busS2_q};
          end else if (!bitCnt_q[0]) begin
            byteHold_d = busS2_q[15:8];
          end else begin
            capA_d = ctrl_q[`APR_CB_HBF] ? {capA_q[79:0], byteHold_q, busS2_q[15:8]} :
                                         {capA_q[79:0], busS2_q[15:8], byteHold_q};
          end
        end
      end
      APR_SER_SETUP, APR_SER_LO: begin
        if (cnt_q == (state_q == APR_SER_SETUP ? `APR_CS_SETUP : `APR_SCLK_HALF)) begin
          cnt_d = 8'h0;
          sclk_d = 1'b1;
          // lane bits settle while the clock is low; take them at the rise
          capA_d = {capA_q[94:0], busS2_q[`APR_PIN_LANE_A]};
          capB_d = {capB_q[94:0], busS2_q[`APR_PIN_LANE_B]};
          capC_d = {capC_q[94:0], busS2_q[`APR_PIN_LANE_C]};
          state_d = APR_SER_HI;
        end
      end
      APR_SER_HI: begin
        if (cnt_q == `APR_SCLK_HALF) begin
          cnt_d = 8'h0;
          sclk_d = 1'b0;
          cfgShift_d = {cfgShift_q[30:0], 1'b0};
          bitCnt_d = bitCnt_q + 7'h1;
          state_d = (bitCnt_q == 7'(`APR_SER_BITS - 1)) ? APR_END : APR_SER_LO;
        end
      end
      APR_END: begin
        csN_d = 1'b1;
        done_d = 1'b1;
        state_d = APR_IDLE;
      end
      default: state_d = APR_IDLE;
    endcase
  end

  always_comb begin
    hostOut_d = 16'h0;
    hostOe_d = 16'h0;
    if (ctrl_q[`APR_CB_IFSEL]) begin
      // lane pins 10..8 belong to the device in serial mode
      hostOe_d = 16'h60fe;
      hostOut_d[`APR_PIN_REF_BUFFER_CTRL_BIT] = ctrl_q[`APR_CB_REFPIN];
      hostOut_d[`APR_PIN_CFG_IN] = ctrl_q[`APR_CB_CFGSRC] & cfgShift_q[31];
      hostOut_d[`APR_PIN_HBF] = ctrl_q[`APR_CB_CHAIN_EN];
      hostOut_d[`APR_PIN_SCLK] = sclk_q;
      hostOut_d[5:3] = ctrl_q[`APR_CB_CHAIN_EN] ? ctrl_q[`APR_CB_CHAIN_LSB +: 3] : 3'h0;
      hostOut_d[`APR_PIN_SEL_C] = ctrl_q[`APR_CB_SEL_C];
      hostOut_d[`APR_PIN_SEL_B] = ctrl_q[`APR_CB_SEL_B];
    end else if (ctrl_q[`APR_CB_BYTE]) begin
      hostOe_d[`APR_PIN_HBF] = 1'b1;
      hostOut_d[`APR_PIN_HBF] = ctrl_q[`APR_CB_HBF];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= APR_IDLE;
      cnt_q <= 8'h0;
      bitCnt_q <= 7'h0;
      ctrl_q <= 32'h0;
      cfg_q <= 32'h0;
      cfgShift_q <= 32'h0;
      done_q <= 1'b0;
      capA_q <= '0;
      capB_q <= '0;
      capC_q <= '0;
      byteHold_q <= 8'h0;
      sclk_q <= 1'b0;
      csN_q <= 1'b1;
      rdN_q <= 1'b1;
      busS1_q <= 16'h0;
      busS2_q <= 16'h0;
      hostOut_q <= 16'h0;
      hostOe_q <= 16'h0;
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h0;
      hrdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bitCnt_q <= bitCnt_d;
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      cfgShift_q <= cfgShift_d;
      done_q <= done_d;
      capA_q <= capA_d;
      capB_q <= capB_d;
      capC_q <= capC_d;
      byteHold_q <= byteHold_d;
      sclk_q <= sclk_d;
      csN_q <= csN_d;
      rdN_q <= rdN_d;
      busS1_q <= pins.busLevel;
      busS2_q <= busS1_q;
      hostOut_q <= hostOut_d;
      hostOe_q <= hostOe_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      hrdata_q <= hrdata_d;
    end
  end

  assign pins.hostOut = hostOut_q;
  assign pins.hostOe = hostOe_q;
  assign pins.interfaceSelect = ctrl_q[`APR_CB_IFSEL];
  assign pins.configSourceSelect = ctrl_q[`APR_CB_CFGSRC];
  assign pins.byteMode = ctrl_q[`APR_CB_BYTE];
  assign pins.csN = csN_q;
  assign pins.rdN = rdN_q;
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

// ---- sim/apr_properties.sv ----
`timescale 1ns/1ps
module apr_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] devOe,
  input wire logic [15:0] hostOe,
  input wire logic [15:0] busLevel,
  input wire logic interfaceSelect,
  input wire logic configSourceSelect,
  input wire logic byteMode,
  input wire logic csN,
  input wire logic rdN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // repetitions leave room for the two-flop pin sync and the drive latency
  a_no_bus_contention: assert property ((devOe & hostOe) == 16'h0000)
    else $error("pin driven from both ends");
  a_word_read_drives: assert property ((!interfaceSelect && !byteMode && !csN && !rdN) [*8]
    |-> devOe == 16'hffff)
    else $error("word read without full bus drive");
  a_parallel_idle_free: assert property ((!interfaceSelect && csN) [*8] |-> devOe == 16'h0000)
    else $error("bus held outside a parallel frame");
  a_byte_low_free: assert property ((!interfaceSelect && byteMode) [*4]
    |-> devOe[7:0] == 8'h00)
    else $error("low pins driven in byte mode");
  a_cfg_pin_low: assert property (interfaceSelect && !configSourceSelect |-> !busLevel[13])
    else $error("config input not low in pin configuration");
  a_lane_c_off: assert property ((interfaceSelect && !csN && !busLevel[2]) [*8]
    |-> !busLevel[10])
    else $error("lane C active while deselected");
  a_lane_b_off: assert property ((interfaceSelect && !csN && !busLevel[1]) [*8]
    |-> !busLevel[9])
    else $error("lane B active while deselected");
  a_lane_a_on: assert property ((interfaceSelect && !csN) [*8] |-> devOe[8])
    else $error("lane A not driven in a frame");
  a_chain_pins_input: assert property (interfaceSelect && busLevel[7] |-> devOe[5:3] == 3'b000)
    else $error("chain input pins driven by device");
  a_read_in_frame: assert property (!rdN |-> !csN)
    else $error("read strobe outside a frame");
  a_sclk_idle_low: assert property (interfaceSelect && csN |-> !busLevel[6])
    else $error("serial clock moving outside a frame");
  cover property (!interfaceSelect && byteMode && !rdN);
  cover property (interfaceSelect && !csN && busLevel[7]);
  cover property ($fell(csN) && interfaceSelect && configSourceSelect);
endmodule

// ---- sim/apr_bench.sv ----
`timescale 1ns/1ps
`include "apr_consts.svh"
module apr_bench;
  import apr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apr_set_t sampleSet = '0;
  logic sampleValid = 1'b0;
  logic sampleReady, refBufferOn, hreadyout, acc;
  apr_cfg_t controlWord;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rdv;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  int failures = 0, check_count = 0, pushed = 0;
  logic [15:0] seen[$];
  logic [31:0] sCtl[5] = '{32'h1c2, 32'h042, 32'h086, 32'h106, 32'hee2};
  logic [31:0] sCfg[5] = '{32'h0, 32'h0, 32'h0100005a, 32'h000000a5, 32'h0};
  logic sRef[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [23:0] sA[5] = '{24'h01ffff, 24'h014fff, 24'h0123ff, 24'h012345, 24'h01ffff};
  logic [23:0] sB[5] = '{24'h23ffff, 24'h235fff, 24'hffffff, 24'hffffff, 24'h23ffff};
  logic [23:0] sC[5] = '{24'h45ffff, 24'hffffff, 24'h45ffff, 24'hffffff, 24'h45ffff};
  apr_if bus();
  always #2.5 clk = ~clk;
  apr_device apr_device_inst (.clk(clk), .rst_n(rst_n), .pins(bus.dev), .sampleSet(sampleSet),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .refBufferOn(refBufferOn),
    .controlWord(controlWord));
  apr_host apr_host_inst (.clk(clk), .rst_n(rst_n), .pins(bus.host), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp());
  apr_properties apr_properties_inst (.clk(clk), .rst_n(rst_n), .devOe(bus.devOe),
    .hostOe(bus.hostOe), .busLevel(bus.busLevel), .interfaceSelect(bus.interfaceSelect),
    .configSourceSelect(bus.configSourceSelect), .byteMode(bus.byteMode), .csN(bus.csN),
    .rdN(bus.rdN));
  // the device keeps driving until it sees the strobe rise, so the wire is still valid here
  always @(posedge bus.rdN) seen.push_back(bus.busLevel);
  function automatic logic [15:0] wd(input int k, input int j);
    return {4'ha, 4'(k), 4'h5, 4'(j)};
  endfunction
  function automatic apr_set_t mkSet(input int k);
    apr_set_t s;
    for (int j = 0; j < 6; j++) s[95-16*j -: 16] = wd(k, j);
    return s;
  endfunction
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic run(input logic [31:0] ctrl);
    int n;
    seen.delete();
    ahb(1'b1, `APR_REG_CTRL, ctrl);
    ahb(1'b1, `APR_REG_CTRL, ctrl | 32'h1);
    n = 0;
    do begin
      ahb(1'b0, `APR_REG_STATUS, 32'h0);
      n++;
    end while (rdv[1] !== 1'b1 && n < 2000);
    if (n == 2000) failures++;
    // done rises before the device has seen the frame end through its sync
    repeat (8) @(posedge clk);
  endtask
  task automatic lanes(input int k, input logic [7:0] base, input logic [23:0] list);
    for (int i = 0; i < 6; i++) begin
      if (list[23-4*i -: 4] != 4'hf) begin
        ahb(1'b0, base + 8'(4*i), 32'h0);
        check("lane word", rdv[15:0], wd(k, int'(list[23-4*i -: 4])));
      end
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    sampleValid <= 1'b1;
    sampleSet <= mkSet(0);
    // fill until the buffer refuses; frames below drain it one set each
    repeat (12) begin
      @(negedge clk);
      acc = sampleReady;
      @(posedge clk);
      if (acc) begin
        pushed++;
        sampleSet <= mkSet(pushed);
      end
    end
    sampleValid <= 1'b0;
    check("sets accepted", pushed, 8);
    run(32'h0);
    check("ready after pop", sampleReady, 1'b1);
    check("word reads", seen.size(), 6);
    for (int j = 0; j < 6; j++) begin
      check("bus word", seen[j], wd(0, j));
      ahb(1'b0, `APR_REG_RES_A + 8'(4*j), 32'h0);
      check("stored word", rdv[15:0], wd(0, j));
    end
    for (int h = 1; h >= 0; h--) begin
      run(32'h8 | (32'(h) << 4));
      check("byte reads", seen.size(), 12);
      for (int j = 0; j < 6; j++) begin
        logic [15:0] w;
        w = wd(2 - h, j);
        check("first byte", seen[2*j][15:8], h ? w[15:8] : w[7:0]);
        check("second byte", seen[2*j+1][15:8], h ? w[7:0] : w[15:8]);
      end
    end
    for (int f = 0; f < 5; f++) begin
      ahb(1'b1, `APR_REG_CFG, sCfg[f]);
      run(sCtl[f]);
      check("ref buffers", refBufferOn, sRef[f]);
      if (sCtl[f][2]) check("config word", controlWord, sCfg[f]);
      lanes(3 + f, `APR_REG_RES_A, sA[f]);
      lanes(3 + f, `APR_REG_RES_B, sB[f]);
      lanes(3 + f, `APR_REG_RES_C, sC[f]);
    end
    ahb(1'b0, `APR_REG_RES_A + 8'h08, 32'h0);
    check("chain on lane A", rdv[15:0], 16'hffff);
    ahb(1'b0, `APR_REG_RES_B + 8'h08, 32'h0);
    check("chain on lane B", rdv[15:0], 16'hffff);
    // buffer now empty: the last set is read again
    run(32'h0);
    check("repeated set", seen[0], wd(7, 0));
    ahb(1'b1, `APR_REG_END, 32'hffffffff);
    ahb(1'b0, `APR_REG_END, 32'h0);
    check("unmapped read", rdv, 32'h0);
    give_verdict();
  end
endmodule
